// ---- rtl/ptf_pkg.sv ----
// constants, field layout and carrier types of the port task-file block
// assumes one adapter clock domain shared by all users of the package
`default_nettype none

package ptf_pkg;

   // register byte offsets
   localparam logic [7:0] INT_STS_OFF = 8'h10;
   localparam logic [7:0] INT_MSK_OFF = 8'h14;
   localparam logic [7:0] CTRL_OFF = 8'h18;
   localparam logic [7:0] TFD_OFF = 8'h20;
   localparam logic [7:0] SIG_OFF = 8'h24;

   // task-file copy layout
   localparam int TFD_ERR_LSB = 8;
   localparam int TFD_STS_LSB = 0;
   localparam int STS_BSY_BIT = 7;
   localparam int STS_DRQ_BIT = 3;
   localparam int STS_ERR_BIT = 0;
   localparam logic [7:0] STS_KEEP_SDB = 8'h88;
   localparam logic [7:0] TFD_ERR_RST = 8'h00;
   localparam logic [7:0] TFD_STS_RST = 8'h7f;

   // signature layout and reset value
   localparam int SIG_HI_LSB = 24;
   localparam int SIG_MID_LSB = 16;
   localparam int SIG_LOW_LSB = 8;
   localparam int SIG_CNT_LSB = 0;
   localparam logic [31:0] SIG_RST = 32'h0fffffff;

   // control register
   localparam int CTRL_CLO_BIT = 3;

   // interrupt status / mask bits
   localparam int INT_TF_BIT = 0;
   localparam int INT_SIG_BIT = 1;
   localparam int INT_CLO_BIT = 2;
   localparam int INT_W = 3;
   localparam logic [INT_W-1:0] INT_RST = 3'h0;

   typedef enum logic [1:0]
   {
      FIS_D2H = 2'h0,
      FIS_PIO = 2'h1,
      FIS_SDB = 2'h2
   } ptf_fis_kind_e;

   typedef enum logic [1:0]
   {
      CLO_IDLE = 2'h0,
      CLO_FORCE = 2'h1,
      CLO_WAIT = 2'h3
   } ptf_clo_e;

   // one received frame, presented for one cycle with valid high
   typedef struct packed
   {
      logic valid;
      ptf_fis_kind_e kind;
      logic [7:0] status;
      logic [7:0] error;
      logic [7:0] lba_hi;
      logic [7:0] lba_mid;
      logic [7:0] lba_low;
      logic [7:0] sec_cnt;
   } ptf_fis_s;

endpackage

`default_nettype wire

// ---- rtl/ptf_sig_cap.sv ----
// one-shot capture of the attached drive's signature
// assumes frames and the rearm pulse come from logic on sys_clk_i
`default_nettype none

module ptf_sig_cap
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic rearm_i,
   input wire ptf_pkg::ptf_fis_s fis_i,
   output logic [31:0] sig_o,
   output logic done_o,
   output logic captured_o
);
   import ptf_pkg::*;

   typedef struct packed
   {
      logic [31:0] sig;
      logic done;
      logic cap;
   } ptf_sig_st_s;

   localparam ptf_sig_st_s ST_RST = '{sig: SIG_RST, done: 1'b0, cap: 1'b0};

   ptf_sig_st_s st_r;
   ptf_sig_st_s st_nxt;
   logic take;

   assign take = fis_i.valid && fis_i.kind == FIS_D2H && !st_r.done;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.cap = 1'b0;
      // a new reset sequence reopens the capture window
      if (rearm_i)
      begin
         st_nxt.sig = SIG_RST; // [RL10]
         st_nxt.done = 1'b0;
      end
      else if (take)
      begin
         st_nxt.sig[SIG_HI_LSB +: 8] = fis_i.lba_hi; // [RL11]
         st_nxt.sig[SIG_MID_LSB +: 8] = fis_i.lba_mid;
         st_nxt.sig[SIG_LOW_LSB +: 8] = fis_i.lba_low;
         st_nxt.sig[SIG_CNT_LSB +: 8] = fis_i.sec_cnt;
         st_nxt.done = 1'b1; // [RL9]
         st_nxt.cap = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         st_r <= ST_RST;
      else
         st_r <= st_nxt;
   end

   assign sig_o = st_r.sig;
   assign done_o = st_r.done;
   assign captured_o = st_r.cap;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_sig_once_only: assert property ( // [RL10]
      st_r.done && !rearm_i |=> $stable(sig_o) && done_o)
      else $error("signature changed after capture");

   a_sig_pack_order: assert property ( // [RL11]
      fis_i.valid && fis_i.kind == FIS_D2H && !st_r.done && !rearm_i
      |=> sig_o == {$past(fis_i.lba_hi), $past(fis_i.lba_mid),
                    $past(fis_i.lba_low), $past(fis_i.sec_cnt)})
      else $error("signature packed wrongly");

   a_rearm_wins: assert property ( // [RL10]
      rearm_i |=> sig_o == SIG_RST && !done_o)
      else $error("rearm did not restore the signature");

endmodule

`default_nettype wire

// ---- rtl/ptf_regs.sv ----
// port task-file copy and drive signature registers with interrupt logic
// assumes frames, reset-sequence pulse and register strobes are driven
// by logic on sys_clk_i, one cycle each
//
// Local design decision: strobed register access.
`default_nettype none

// Behaviour
// [RL1] D2H register, PIO setup and set-device-bits frames update the copy.
// [RL2] A set-device-bits frame leaves the busy and data-request bits alone.
// [RL3] Copy bits 15:8 hold the latest error byte and reset to zero.
// [RL4] Copy bits 7:0 hold the latest status byte and reset to 7Fh.
// [RL5] The whole status byte is copied, command-specific bits included.
// [RL6] Status bit 7 is the drive-busy flag used by the adapter.
// [RL7] Status bit 3 is the data-request flag used by the adapter.
// [RL8] Status bit 0 is the drive error flag used by the adapter.
// [RL9] The signature takes the fields of the first D2H register frame.
// [RL10] The signature is written once per reset sequence and then holds.
// [RL11] The signature packs LBA high, mid, low and sector count from bit 31.
// [RL12] The override forces busy and data-request low, then clears itself.
// [RL13] Copy bits 31:16 read zero and software writes to both are ignored.
module ptf_regs
#(
   parameter int AW = 8
)
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [AW-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire ptf_pkg::ptf_fis_s fis_i,
   input wire logic port_reset_i,
   output logic drive_busy_flag_o,
   output logic data_request_flag_o,
   output logic drive_error_o,
   output logic sig_valid_o,
   output logic irq_o
);
   import ptf_pkg::*;

   if (AW < 8)
   begin : g_aw_check
      $error("address width too small for the register map");
   end

   typedef struct packed
   {
      logic [7:0] err;
      logic [7:0] sts;
      ptf_clo_e command_list_override;
      logic [INT_W-1:0] ists;
      logic [INT_W-1:0] imsk;
      logic [31:0] rdata;
      logic irq;
   } ptf_regs_st_s;

   // reset image: copy reads 0000007fh, override idle, no interrupt
   localparam ptf_regs_st_s ST_RST = '{
      err: TFD_ERR_RST,
      sts: TFD_STS_RST,
      command_list_override: CLO_IDLE,
      ists: INT_RST,
      imsk: INT_RST,
      rdata: 32'h0,
      irq: 1'b0
   };

   ptf_regs_st_s st_r;
   ptf_regs_st_s st_nxt;

   logic [31:0] sig_w;
   logic sig_done_w;
   logic sig_cap_w;
   logic clo_set;
   logic rd_ists;
   logic [INT_W-1:0] ev;

   // address compare shared by strobes, read mux and checks
   function automatic logic hit
   (
      input logic [AW-1:0] a,
      input logic [7:0] off
   );
      return a == AW'(off);
   endfunction

   // capture sits apart so no register write can reach its one-shot state
   ptf_sig_cap ptf_sig_cap_i
   (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .rearm_i(port_reset_i), // [RL10]
      .fis_i(fis_i),
      .sig_o(sig_w), // [RL9] [RL11]
      .done_o(sig_done_w),
      .captured_o(sig_cap_w)
   );

   // only a written one starts an override; a written zero does nothing
   assign clo_set = reg_wr_i && hit(reg_addr_i, CTRL_OFF)
      && reg_wdata_i[CTRL_CLO_BIT];
   assign rd_ists = reg_rd_i && hit(reg_addr_i, INT_STS_OFF);

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rdata = 32'h0;
      ev = '0;

      // frame capture into the task-file copy
      if (fis_i.valid)
      begin
         st_nxt.err = fis_i.error; // [RL3]
         ev[INT_TF_BIT] = 1'b1; // [RL1]
         if (fis_i.kind == FIS_SDB)
         begin
            // busy and data-request are not carried by this frame
            st_nxt.sts = (fis_i.status & ~STS_KEEP_SDB)
               | (st_r.sts & STS_KEEP_SDB); // [RL2]
         end
         else
         begin
            st_nxt.sts = fis_i.status; // [RL4] [RL5]
         end
      end

      // override sequence; forcing runs after capture so it wins
      case (st_r.command_list_override)
         CLO_IDLE:
         begin
            if (clo_set)
               st_nxt.command_list_override = CLO_FORCE;
         end
         CLO_FORCE:
         begin
            st_nxt.sts[STS_BSY_BIT] = 1'b0; // [RL12] [RL6]
            st_nxt.sts[STS_DRQ_BIT] = 1'b0; // [RL12] [RL7]
            st_nxt.command_list_override = CLO_WAIT;
         end
         CLO_WAIT:
         begin
            // defensive only: forcing always precedes this state
            if (!st_r.sts[STS_BSY_BIT] && !st_r.sts[STS_DRQ_BIT])
            begin
               st_nxt.command_list_override = CLO_IDLE; // [RL12]
               ev[INT_CLO_BIT] = 1'b1;
            end
            else
            begin
               st_nxt.command_list_override = CLO_FORCE;
            end
         end
         default:
         begin
            st_nxt.command_list_override = CLO_IDLE;
         end
      endcase

      ev[INT_SIG_BIT] = sig_cap_w;

      // read clears the sticky bits; a same-cycle event still lands
      st_nxt.ists = (rd_ists ? INT_RST : st_r.ists) | ev;

      if (reg_wr_i && hit(reg_addr_i, INT_MSK_OFF))
         st_nxt.imsk = reg_wdata_i[INT_W-1:0];

      st_nxt.irq = |(st_nxt.ists & st_nxt.imsk);

      // read data stand for the single cycle after the strobe
      if (reg_rd_i)
      begin
         if (hit(reg_addr_i, TFD_OFF))
         begin
            st_nxt.rdata[TFD_ERR_LSB +: 8] = st_r.err; // [RL13]
            st_nxt.rdata[TFD_STS_LSB +: 8] = st_r.sts;
         end
         else if (hit(reg_addr_i, SIG_OFF))
         begin
            st_nxt.rdata = sig_w;
         end
         else if (hit(reg_addr_i, INT_STS_OFF))
         begin
            st_nxt.rdata[INT_W-1:0] = st_r.ists;
         end
         else if (hit(reg_addr_i, INT_MSK_OFF))
         begin
            st_nxt.rdata[INT_W-1:0] = st_r.imsk;
         end
         else if (hit(reg_addr_i, CTRL_OFF))
         begin
            st_nxt.rdata[CTRL_CLO_BIT] = (st_r.command_list_override != CLO_IDLE);
         end
      end
   end

   // one register stage for all state but the signature; outputs other than sig_valid_o tap it directly
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         st_r <= ST_RST;
      else
         st_r <= st_nxt;
   end

   assign reg_rdata_o = st_r.rdata;
   assign drive_busy_flag_o = st_r.sts[STS_BSY_BIT]; // [RL6]
   assign data_request_flag_o = st_r.sts[STS_DRQ_BIT]; // [RL7]
   assign drive_error_o = st_r.sts[STS_ERR_BIT]; // [RL8]
   assign sig_valid_o = sig_done_w;
   assign irq_o = st_r.irq;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_full_frame;
      fis_i.valid && fis_i.kind != FIS_SDB && st_r.command_list_override == CLO_IDLE;
   endsequence

   sequence s_sdb_frame;
      fis_i.valid && fis_i.kind == FIS_SDB && st_r.command_list_override == CLO_IDLE;
   endsequence

   sequence s_clo_request;
      clo_set && st_r.command_list_override == CLO_IDLE;
   endsequence

   sequence s_quiet;
      !fis_i.valid;
   endsequence

   a_status_copy_full: assert property ( // [RL1]
      s_full_frame |=> st_r.sts == $past(fis_i.status))
      else $error("status byte not copied whole");

   a_error_copy_any: assert property ( // [RL3]
      fis_i.valid |=> st_r.err == $past(fis_i.error))
      else $error("error byte not copied");

   a_sdb_keeps_flags: assert property ( // [RL2]
      s_sdb_frame |=> drive_busy_flag_o == $past(drive_busy_flag_o)
         && data_request_flag_o == $past(data_request_flag_o)
         && st_r.sts[6:4] == $past(fis_i.status[6:4]))
      else $error("set-device-bits frame disturbed busy or drq");

   a_err_flag_follow: assert property ( // [RL8]
      fis_i.valid && st_r.command_list_override == CLO_IDLE
      |=> drive_error_o == $past(fis_i.status[STS_ERR_BIT]))
      else $error("error flag does not follow the frame");

   a_tfd_reset_value: assert property ( // [RL4]
      disable iff (1'b0)
      sys_rst_i |=> st_r.sts == TFD_STS_RST && st_r.err == TFD_ERR_RST)
      else $error("task-file copy reset value wrong");

   a_clo_forces_zero: assert property ( // [RL12]
      s_clo_request ##1 s_quiet
      |=> !drive_busy_flag_o && !data_request_flag_o)
      else $error("override did not clear busy and drq");

   a_clo_self_clear: assert property ( // [RL12]
      s_clo_request ##1 s_quiet ##1 s_quiet
      |=> st_r.command_list_override == CLO_IDLE && st_r.ists[INT_CLO_BIT])
      else $error("override bit not released");

   a_tfd_rsvd_zero: assert property ( // [RL13]
      reg_rd_i && hit(reg_addr_i, TFD_OFF)
      |=> reg_rdata_o[31:16] == 16'h0
         && reg_rdata_o[15:0] == $past({st_r.err, st_r.sts}))
      else $error("task-file read value wrong");

   a_tfd_write_ignored: assert property ( // [RL13]
      reg_wr_i && (hit(reg_addr_i, TFD_OFF) || hit(reg_addr_i, SIG_OFF))
      && !fis_i.valid && st_r.command_list_override == CLO_IDLE && !port_reset_i
      |=> $stable(st_r.sts) && $stable(st_r.err) && $stable(sig_w))
      else $error("software write changed a read-only register");

   a_read_only_once: assert property (
      !reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data outside the answer cycle");

   a_irq_follows: assert property (
      fis_i.valid && st_r.imsk[INT_TF_BIT]
      && !(reg_wr_i && hit(reg_addr_i, INT_MSK_OFF)) |=> irq_o)
      else $error("unmasked event did not raise the interrupt");

   a_irq_masked_low: assert property (
      st_r.imsk == INT_RST && !(reg_wr_i && hit(reg_addr_i, INT_MSK_OFF))
      |=> !irq_o)
      else $error("interrupt raised with every source masked");

   a_sticky_set_wins: assert property (
      rd_ists && fis_i.valid |=> st_r.ists[INT_TF_BIT])
      else $error("event lost on status read");

   // checks below watch the registered state one edge after each cause
   a_tfd_event_set: assert property ( // [RL1]
      fis_i.valid |=> st_r.ists[INT_TF_BIT])
      else $error("task-file update event not recorded");

   a_sts_idle_hold: assert property ( // [RL4]
      !fis_i.valid && st_r.command_list_override == CLO_IDLE
      |=> $stable(st_r.sts) && $stable(st_r.err))
      else $error("task-file copy changed without a frame");

   a_clo_wins_frame: assert property ( // [RL12]
      st_r.command_list_override == CLO_FORCE
      |=> !drive_busy_flag_o && !data_request_flag_o)
      else $error("frame during override left busy or drq set");

   a_clo_done_idle: assert property ( // [RL12]
      st_r.command_list_override == CLO_WAIT
      |=> st_r.command_list_override == CLO_IDLE && st_r.ists[INT_CLO_BIT])
      else $error("override did not finish after forcing");

   a_clo_zero_write: assert property ( // [RL12]
      reg_wr_i && hit(reg_addr_i, CTRL_OFF) && !reg_wdata_i[CTRL_CLO_BIT]
      && st_r.command_list_override == CLO_IDLE
      |=> st_r.command_list_override == CLO_IDLE)
      else $error("written zero started an override");

   a_ctrl_reads_busy: assert property ( // [RL12]
      reg_rd_i && hit(reg_addr_i, CTRL_OFF)
      |=> reg_rdata_o == {28'h0, $past(st_r.command_list_override != CLO_IDLE), 3'h0})
      else $error("override bit read back wrongly");

   // only reads with no event beside them are expected to empty the bits
   a_ists_read_clear: assert property (
      rd_ists && !fis_i.valid && !sig_cap_w && st_r.command_list_override != CLO_WAIT
      |=> st_r.ists == INT_RST
         && reg_rdata_o[INT_W-1:0] == $past(st_r.ists))
      else $error("status read did not return and clear the bits");

   a_sig_event_set: assert property ( // [RL9]
      sig_cap_w |=> st_r.ists[INT_SIG_BIT])
      else $error("signature capture event not recorded");

   a_sig_read_value: assert property ( // [RL9]
      reg_rd_i && hit(reg_addr_i, SIG_OFF)
      |=> reg_rdata_o == $past(sig_w))
      else $error("signature read value wrong");

endmodule

`default_nettype wire

// ---- tb/ptf_drive_model.sv ----
// drive-side model: sends one frame per call of send
// assumes the bench calls send from its own clocked process
`default_nettype none

module ptf_drive_model
(
   input wire logic sys_clk_i,
   output ptf_pkg::ptf_fis_s fis_o
);
   import ptf_pkg::*;

   initial fis_o = '0;

   task automatic send(input ptf_fis_kind_e k, input logic [7:0] s, e,
      input logic [31:0] sg);
      @(posedge sys_clk_i);
      fis_o <= {1'b1, k, s, e, sg};
      @(posedge sys_clk_i);
      // stale fields are inverted so the block cannot lean on them
      fis_o <= {1'b0, ~k, ~s, ~e, ~sg};
   endtask
endmodule

`default_nettype wire

// ---- tb/ptf_regs_tb.sv ----
// self-checking bench for the task-file copy and signature registers
// assumes the package, ptf_regs and the drive model are compiled first
`default_nettype none

module ptf_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ptf_pkg::*;

   logic sys_clk, sys_rst, reg_wr, reg_rd, port_reset;
   logic busy, data_request_flag, derr, sig_valid, irq;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv;
   ptf_fis_s fis;
   int fail_count = 0;
   int num_checks = 0;

   ptf_regs #(.AW(8)) ptf_regs_i (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .fis_i(fis),
      .port_reset_i(port_reset), .drive_busy_flag_o(busy),
      .data_request_flag_o(data_request_flag), .drive_error_o(derr),
      .sig_valid_o(sig_valid), .irq_o(irq));

   ptf_drive_model ptf_drive_model_i (.sys_clk_i(sys_clk), .fis_o(fis));

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      rd(a, rv);
      check(rv, exp);
   endtask

   task automatic t_reset;
      #1 check({busy, data_request_flag, derr, sig_valid, irq}, 5'b01100);
      rdc(TFD_OFF, 32'h7f);
      rdc(SIG_OFF, 32'h0fffffff);
      rdc(8'h3c, 32'h0);
   endtask

   task automatic t_irq;
      wr(INT_MSK_OFF, 32'h1);
      ptf_drive_model_i.send(FIS_PIO, 8'h00, 8'h00, 32'h0);
      repeat (2) @(posedge sys_clk);
      #1 check(irq, 1'b1);
      rdc(INT_STS_OFF, 32'h1);
      repeat (2) @(posedge sys_clk);
      #1 check(irq, 1'b0);
      wr(INT_MSK_OFF, 32'h0);
      ptf_drive_model_i.send(FIS_PIO, 8'h00, 8'h00, 32'h0);
      repeat (2) @(posedge sys_clk);
      #1 check(irq, 1'b0);
      rdc(INT_STS_OFF, 32'h1);
      // a frame beside the status read must survive the clear
      fork
         ptf_drive_model_i.send(FIS_PIO, 8'h00, 8'h00, 32'h0);
         rd(INT_STS_OFF, rv);
      join
      check(rv, 32'h0);
      rdc(INT_STS_OFF, 32'h1);
   endtask

   task automatic t_d2h;
      ptf_drive_model_i.send(FIS_D2H, 8'hd9, 8'h5a, 32'h11223344);
      #1 check({busy, data_request_flag, derr, sig_valid}, 4'hf);
      rdc(TFD_OFF, 32'h5ad9);
      rdc(SIG_OFF, 32'h11223344);
      ptf_drive_model_i.send(FIS_D2H, 8'h40, 8'h00, 32'haabbccdd);
      #1 check({busy, data_request_flag, derr}, 3'h0);
      rdc(SIG_OFF, 32'h11223344);
      @(posedge sys_clk);
      port_reset <= 1'b1;
      @(posedge sys_clk);
      port_reset <= 1'b0;
      #1 check(sig_valid, 1'b0);
      rdc(SIG_OFF, 32'h0fffffff);
      ptf_drive_model_i.send(FIS_D2H, 8'h50, 8'h01, 32'h01020304);
      rdc(SIG_OFF, 32'h01020304);
   endtask

   task automatic t_sdb;
      ptf_drive_model_i.send(FIS_PIO, 8'h88, 8'h00, 32'h0);
      rdc(TFD_OFF, 32'h0088);
      ptf_drive_model_i.send(FIS_SDB, 8'h77, 8'ha5, 32'h0);
      rdc(TFD_OFF, 32'ha5ff);
      ptf_drive_model_i.send(FIS_SDB, 8'h00, 8'h00, 32'h0);
      rdc(TFD_OFF, 32'h0088);
   endtask

   task automatic t_clo;
      wr(CTRL_OFF, 32'h0);
      rdc(CTRL_OFF, 32'h0);
      rdc(TFD_OFF, 32'h0088);
      rd(INT_STS_OFF, rv);
      wr(CTRL_OFF, 32'h8);
      rv = 32'h1;
      for (int i = 0; i < 8 && rv !== 32'h0; i++)
         rd(CTRL_OFF, rv);
      if (rv !== 32'h0)
      begin
         fail_count++;
         stop_test;
      end
      check({busy, data_request_flag}, 2'h0);
      rdc(TFD_OFF, 32'h0000);
      rdc(INT_STS_OFF, 32'h4);
      // a frame in the forcing cycle loses bits 7 and 3 only
      fork
         wr(CTRL_OFF, 32'h8);
         begin
            @(posedge sys_clk);
            ptf_drive_model_i.send(FIS_PIO, 8'h89, 8'h00, 32'h0);
         end
      join
      rdc(TFD_OFF, 32'h0001);
      rdc(INT_STS_OFF, 32'h5);
   endtask

   task automatic t_ro;
      wr(TFD_OFF, 32'hffffffff);
      wr(SIG_OFF, 32'h0);
      rdc(TFD_OFF, 32'h0001);
      rdc(SIG_OFF, 32'h01020304);
   endtask

   initial
   begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      port_reset = 1'b0;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_reset;
      t_irq;
      t_d2h;
      t_sdb;
      t_clo;
      t_ro;
      stop_test;
   end
endmodule

`default_nettype wire
